// ---- shared/amd_defines.vh ----
// Constants for the addressing-mode decoder and operand fetcher
`ifndef AMD_DEFINES_VH
`define AMD_DEFINES_VH

// ----------------------------------------------------------------------
// Addressing modes (17), selected on i_mode
// ----------------------------------------------------------------------
`define AMD_M_INH        5'h00
`define AMD_M_IMM        5'h01
`define AMD_M_DIR_S      5'h02
`define AMD_M_DIR_L      5'h03
`define AMD_M_IDX_0      5'h04
`define AMD_M_IDX_S      5'h05
`define AMD_M_IDX_L      5'h06
`define AMD_M_IND_S      5'h07
`define AMD_M_IND_L      5'h08
`define AMD_M_IIX_S      5'h09
`define AMD_M_IIX_L      5'h0a
`define AMD_M_REL_D      5'h0b
`define AMD_M_REL_I      5'h0c
`define AMD_M_BIT_D      5'h0d
`define AMD_M_BIT_I      5'h0e
`define AMD_M_BTJ_D      5'h0f
`define AMD_M_BTJ_I      5'h10
`define AMD_M_COUNT      5'h11

// ----------------------------------------------------------------------
// Mode families (7), shown on o_family
// ----------------------------------------------------------------------
`define AMD_F_INH        3'h0
`define AMD_F_IMM        3'h1
`define AMD_F_DIR        3'h2
`define AMD_F_IDX        3'h3
`define AMD_F_IND        3'h4
`define AMD_F_REL        3'h5
`define AMD_F_BIT        3'h6

// ----------------------------------------------------------------------
// Inherent operations, selected on i_inh_op
// ----------------------------------------------------------------------
`define AMD_OP_OTHER     2'h0
`define AMD_OP_MASK      2'h1
`define AMD_OP_UNMASK    2'h2
`define AMD_OP_WAIT      2'h3

// ----------------------------------------------------------------------
// Constants and reset values
// ----------------------------------------------------------------------
`define AMD_Y_PREFIX     8'h90
`define AMD_MASK_HIGH    2'h3
`define AMD_MASK_LOW     2'h0
`define AMD_MASK_RST     2'h3
`define AMD_PC_RST       16'h0000
`define AMD_PAGE0_HI     8'h00

`endif

// ---- rtl/amd_decoder.v ----
// Addressing-mode decoder and effective-address generator
`include "amd_defines.vh"
`default_nettype none

module amd_decoder #(
  parameter AW = 16
) (
  input  wire          i_clk,
  input  wire          i_nrst,
  input  wire          i_start,
  input  wire [4:0]    i_mode,
  input  wire          i_rmw,
  input  wire [1:0]    i_inh_op,
  input  wire          i_halt_op,
  input  wire [7:0]    i_prefix,
  input  wire [7:0]    i_idx_x,
  input  wire [7:0]    i_idx_y,
  input  wire [AW-1:0] i_pc,
  input  wire [7:0]    i_rdata,
  input  wire          i_irq,
  output reg  [AW-1:0] o_addr,
  output reg           o_rd,
  output reg  [AW-1:0] o_ea,
  output reg  [7:0]    o_operand,
  output reg           o_done,
  output reg           o_illegal,
  output reg  [2:0]    o_family,
  output reg  [AW-1:0] o_next_pc,
  output reg  [1:0]    o_imask,
  output reg           o_halt,
  output reg           o_wait,
  output reg           o_busy
);

  // --------------------------------------------------------------------
  // States
  // --------------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_OPB1 = 3'h1;
  localparam [2:0] S_OPB2 = 3'h2;
  localparam [2:0] S_PTR1 = 3'h3;
  localparam [2:0] S_PTR2 = 3'h4;
  localparam [2:0] S_DONE = 3'h5;
  localparam [2:0] S_SLP  = 3'h6;

  // --------------------------------------------------------------------
  // Mode property decoding, used at start and in the sequencer
  // --------------------------------------------------------------------
  // Operand bytes after the opcode
  function [1:0] op_len;
    input [4:0] m;
    begin
      case (m)
        `AMD_M_INH,
        `AMD_M_IDX_0:                op_len = 2'd0;
        `AMD_M_IMM:                  op_len = 2'd1;
        `AMD_M_DIR_S, `AMD_M_IDX_S:  op_len = 2'd1;
        `AMD_M_IND_S, `AMD_M_IND_L,
        `AMD_M_IIX_S, `AMD_M_IIX_L,
        `AMD_M_REL_D, `AMD_M_REL_I,
        `AMD_M_BIT_D, `AMD_M_BIT_I:  op_len = 2'd1;
        // Bit-test jumps carry an address byte and a jump offset
        `AMD_M_DIR_L, `AMD_M_IDX_L,
        `AMD_M_BTJ_D, `AMD_M_BTJ_I:  op_len = 2'd2;
        default:                     op_len = 2'd0;
      endcase
    end
  endfunction

  // Memory-held pointer: 0 none, 1 byte, 2 word
  function [1:0] ptr_len;
    input [4:0] m;
    begin
      case (m)
        `AMD_M_IND_S, `AMD_M_IIX_S, `AMD_M_REL_I,
        `AMD_M_BIT_I, `AMD_M_BTJ_I: ptr_len = 2'd1;
        `AMD_M_IND_L, `AMD_M_IIX_L: ptr_len = 2'd2;
        default:                    ptr_len = 2'd0;
      endcase
    end
  endfunction

  // Family of a mode
  function [2:0] fam;
    input [4:0] m;
    begin
      case (m)
        `AMD_M_INH:                  fam = `AMD_F_INH;
        `AMD_M_IMM:                  fam = `AMD_F_IMM;
        `AMD_M_DIR_S, `AMD_M_DIR_L:  fam = `AMD_F_DIR;
        `AMD_M_IDX_0, `AMD_M_IDX_S,
        `AMD_M_IDX_L:                fam = `AMD_F_IDX;
        `AMD_M_REL_D, `AMD_M_REL_I:  fam = `AMD_F_REL;
        `AMD_M_BIT_D, `AMD_M_BIT_I,
        `AMD_M_BTJ_D, `AMD_M_BTJ_I:  fam = `AMD_F_BIT;
        default:                     fam = `AMD_F_IND;
      endcase
    end
  endfunction

  // Long forms, refused for read-modify-write
  function is_long;
    input [4:0] m;
    begin
      is_long = (m == `AMD_M_DIR_L) || (m == `AMD_M_IDX_L) ||
                (m == `AMD_M_IND_L) || (m == `AMD_M_IIX_L);
    end
  endfunction

  // Modes that add the index register
  function is_indexed;
    input [4:0] m;
    begin
      is_indexed = (m == `AMD_M_IDX_0) || (m == `AMD_M_IDX_S) ||
                   (m == `AMD_M_IDX_L) || (m == `AMD_M_IIX_S) ||
                   (m == `AMD_M_IIX_L);
    end
  endfunction

  // --------------------------------------------------------------------
  // Reset synchroniser
  // --------------------------------------------------------------------
  reg rst_s1_q;
  reg rst_s2_q;

  // Two-stage release; assertion stays asynchronous
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_s1_q <= 1'b0;
      rst_s2_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_s2_q <= rst_s1_q;
    end
  end

  wire rst_n = rst_s2_q;

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  reg [2:0]    st_q;
  reg [4:0]    mode_q;
  reg [7:0]    idx_q;
  reg [1:0]    left_q;
  reg [15:0]   word_q;
  reg [AW-1:0] fetch_q;

  // Words assemble high byte first
  wire [15:0] word_sh = {word_q[7:0], i_rdata};
  wire [15:0] pc_p1   = i_pc + 16'h0001;
  // Bit-test jumps fetch the pointer address before the offset, so
  // their pointer address is the byte already held, not the new one
  wire [7:0]  ptr_at  = (mode_q == `AMD_M_BTJ_I) ? word_q[7:0] : i_rdata;

  // Effective address from the assembled word
  function [15:0] form_ea;
    input [4:0]  m;
    input [15:0] w;
    input [7:0]  ix;
    begin
      case (m)
        `AMD_M_DIR_S, `AMD_M_IND_S, `AMD_M_BIT_D,
        `AMD_M_BIT_I, `AMD_M_BTJ_I, `AMD_M_REL_I:
          form_ea = {`AMD_PAGE0_HI, w[7:0]};
        // Address byte came first, so it sits above the jump offset
        `AMD_M_BTJ_D:
          form_ea = {`AMD_PAGE0_HI, w[15:8]};
        `AMD_M_IDX_0:
          form_ea = {`AMD_PAGE0_HI, ix};
        `AMD_M_IDX_S, `AMD_M_IIX_S:
          form_ea = {8'h00, w[7:0]} + {8'h00, ix};
        `AMD_M_IDX_L, `AMD_M_IIX_L:
          form_ea = w + {8'h00, ix};
        default:
          form_ea = w;
      endcase
    end
  endfunction

  // Main control, mask and low-power state
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q      <= S_IDLE;
      mode_q    <= 5'h00;
      idx_q     <= 8'h00;
      left_q    <= 2'd0;
      word_q    <= 16'h0000;
      fetch_q   <= `AMD_PC_RST;
      o_addr    <= `AMD_PC_RST;
      o_rd      <= 1'b0;
      o_ea      <= 16'h0000;
      o_operand <= 8'h00;
      o_done    <= 1'b0;
      o_illegal <= 1'b0;
      o_family  <= `AMD_F_INH;
      o_next_pc <= `AMD_PC_RST;
      o_imask   <= `AMD_MASK_RST;
      o_halt    <= 1'b0;
      o_wait    <= 1'b0;
      o_busy    <= 1'b0;
    end else begin
      o_done    <= 1'b0;
      o_illegal <= 1'b0;
      o_rd      <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (i_start) begin
            mode_q    <= i_mode;
            o_family  <= fam(i_mode);
            // Prefix swaps X for Y
            idx_q     <= (i_prefix == `AMD_Y_PREFIX) ? i_idx_y
                                                     : i_idx_x;
            left_q    <= op_len(i_mode);
            word_q    <= 16'h0000;
            // Past opcode plus all operand bytes
            o_next_pc <= pc_p1 + {14'h0000, op_len(i_mode)};
            if (i_mode >= `AMD_M_COUNT ||
                (i_rmw && is_long(i_mode))) begin
              o_illegal <= 1'b1;
              o_done    <= 1'b1;
            end else if (op_len(i_mode) == 2'd0) begin
              // No bytes to fetch; finish next cycle, unless a wait or halt sleeps first
              st_q   <= S_DONE;
              o_busy <= 1'b1;
              if (i_mode == `AMD_M_INH) begin
                if (i_inh_op == `AMD_OP_MASK)
                  o_imask <= `AMD_MASK_HIGH;
                if (i_inh_op == `AMD_OP_UNMASK)
                  o_imask <= `AMD_MASK_LOW;
                if (i_inh_op == `AMD_OP_WAIT || i_halt_op) begin
                  st_q   <= S_SLP;
                  o_wait <= !i_halt_op;
                  o_halt <= i_halt_op;
                end
              end
            end else begin
              st_q    <= S_OPB1;
              o_busy  <= 1'b1;
              o_addr  <= pc_p1;
              fetch_q <= pc_p1;
              o_rd    <= 1'b1;
            end
          end
        end
        S_OPB1, S_OPB2: begin
          // Read data returns the cycle after o_rd
          if (!o_rd) begin
            word_q <= word_sh;
            if (left_q == 2'd2) begin
              left_q  <= 2'd1;
              st_q    <= S_OPB2;
              o_addr  <= fetch_q + 16'h0001;
              fetch_q <= fetch_q + 16'h0001;
              o_rd    <= 1'b1;
            end else if (mode_q == `AMD_M_IMM) begin
              o_operand <= i_rdata;
              st_q      <= S_DONE;
            end else if (ptr_len(mode_q) != 2'd0) begin
              // Pointer lives in page zero
              o_addr  <= {`AMD_PAGE0_HI, ptr_at};
              fetch_q <= {`AMD_PAGE0_HI, ptr_at};
              // Keep the jump offset; the pointer read reuses i_rdata
              if (mode_q == `AMD_M_BTJ_I)
                o_operand <= i_rdata;
              left_q  <= ptr_len(mode_q);
              word_q  <= 16'h0000;
              o_rd    <= 1'b1;
              st_q    <= S_PTR1;
            end else begin
              o_ea <= form_ea(mode_q, word_sh, idx_q);
              if (mode_q == `AMD_M_REL_D || mode_q == `AMD_M_BTJ_D)
                o_operand <= i_rdata;
              st_q <= S_DONE;
            end
          end
        end
        S_PTR1, S_PTR2: begin
          if (!o_rd) begin
            word_q <= word_sh;
            if (left_q == 2'd2) begin
              // Word pointer: low byte at next address
              left_q  <= 2'd1;
              st_q    <= S_PTR2;
              o_addr  <= {`AMD_PAGE0_HI, fetch_q[7:0] + 8'h01};
              o_rd    <= 1'b1;
            end else begin
              // Last pointer byte in; indirect indexed adds the index
              o_ea <= form_ea(mode_q, word_sh, idx_q);
              if (mode_q == `AMD_M_REL_I)
                o_operand <= i_rdata;
              st_q <= S_DONE;
            end
          end
        end
        S_DONE: begin
          if (mode_q == `AMD_M_IDX_0)
            o_ea <= form_ea(mode_q, word_q, idx_q);
          o_done <= 1'b1;
          o_busy <= 1'b0;
          st_q   <= S_IDLE;
        end
        S_SLP: begin
          // Only an interrupt ends either low-power state
          if (i_irq) begin
            o_wait <= 1'b0;
            o_halt <= 1'b0;
            st_q   <= S_DONE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

// ---- sim/amd_decoder_props.sv ----
// Concurrent checks on the addressing-mode decoder ports
`include "amd_defines.vh"
`default_nettype none

module amd_decoder_props #(
  parameter AW = 16
) (
  input wire logic          i_clk,
  input wire logic          i_nrst,
  input wire logic          i_start,
  input wire logic [4:0]    i_mode,
  input wire logic          i_rmw,
  input wire logic [1:0]    i_inh_op,
  input wire logic          i_halt_op,
  input wire logic [7:0]    i_prefix,
  input wire logic [7:0]    i_idx_x,
  input wire logic [AW-1:0] i_pc,
  input wire logic [AW-1:0] o_addr,
  input wire logic          o_rd,
  input wire logic [AW-1:0] o_ea,
  input wire logic          o_done,
  input wire logic          o_illegal,
  input wire logic [AW-1:0] o_next_pc,
  input wire logic [1:0]    o_imask,
  input wire logic          o_busy
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic          go;
  logic [AW-1:0] pc_q;
  logic [7:0]    x_q;
  assign go = i_start && !o_busy;

  // Keep the opcode address and index, since the inputs may move on
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pc_q <= '0;
      x_q  <= 8'h00;
    end else if (go) begin
      pc_q <= i_pc;
      x_q  <= i_idx_x;
    end
  end

  sequence s_take(logic [4:0] m);
    go && i_mode == m;
  endsequence
  sequence s_fetch(logic [AW-1:0] a);
    o_rd && o_addr == a ##1 !o_rd;
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  done_pulse_a: assert property (o_done |=> !o_done)
    else $error("done lasted more than one cycle");
  read_busy_a: assert property (o_rd |-> o_busy)
    else $error("read strobe outside a sequence");
  bad_mode_a: assert property (go && i_mode > 5'h10 |=> o_done && o_illegal)
    else $error("unknown mode not refused");
  rmw_long_a: assert property (go && i_rmw &&
      (i_mode inside {`AMD_M_DIR_L, `AMD_M_IDX_L, `AMD_M_IND_L,
      `AMD_M_IIX_L}) |=> o_done && o_illegal)
    else $error("long form accepted for read-modify-write");
  inh_len_a: assert property (s_take(`AMD_M_INH) and
      (i_inh_op != `AMD_OP_WAIT && !i_halt_op)
      |=> ##1 o_done && !o_illegal && o_next_pc == pc_q + 1'b1)
    else $error("inherent length wrong");
  mask_high_a: assert property (s_take(`AMD_M_INH) and (!i_halt_op &&
      i_inh_op == `AMD_OP_MASK) |=> ##[0:1] o_imask == `AMD_MASK_HIGH)
    else $error("mask not raised to level 3");
  mask_low_a: assert property (s_take(`AMD_M_INH) and (!i_halt_op &&
      i_inh_op == `AMD_OP_UNMASK) |=> ##[0:1] o_imask == `AMD_MASK_LOW)
    else $error("mask not lowered to level 0");
  dir_short_a: assert property (s_take(`AMD_M_DIR_S)
      |=> s_fetch(pc_q + 1'b1) ##2 o_done && o_ea[15:8] == 8'h00)
    else $error("short direct fetch wrong");
  dir_long_a: assert property (s_take(`AMD_M_DIR_L) and !i_rmw
      |=> s_fetch(pc_q + 1'b1) ##1 s_fetch(pc_q + 2'h2) ##2 o_done)
    else $error("long direct fetch order wrong");
  idx_none_a: assert property (s_take(`AMD_M_IDX_0) and
      i_prefix != `AMD_Y_PREFIX |=> ##1 o_done && o_ea == {8'h00, x_q})
    else $error("no-offset index address wrong");
endmodule

bind amd_decoder amd_decoder_props #(.AW(AW)) u_amd_decoder_props (.*);
`default_nettype wire

// ---- sim/amd_mem_model.sv ----
// Program and data memory answering the decoder's read strobe
`default_nettype none

module amd_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_rd,
  input  wire logic [15:0] i_addr,
  output var  logic [7:0]  o_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [0:65535];

  // Filler so that unset places never read as unknown
  initial begin
    for (int a = 0; a < 65536; a++) mem[a] = 8'ha5;
  end

  // Data valid for one cycle; toggles after so stale bytes are caught
  always @(posedge i_clk) begin
    if (i_rd) o_rdata <= mem[i_addr];
    else o_rdata <= ~o_rdata;
  end
endmodule
`default_nettype wire

// ---- sim/amd_decoder_tb_top.sv ----
// Self-checking bench for the addressing-mode decoder
`include "amd_defines.vh"
`default_nettype none

module amd_decoder_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam D = 5;
  logic i_clk = 0, i_nrst = 0, i_start = 0, i_rmw = 0, i_halt_op = 0;
  logic i_irq = 0, o_rd, o_done, o_illegal, o_halt, o_wait, o_busy, ill;
  logic [4:0] i_mode = 0;
  logic [1:0] i_inh_op = 0, o_imask;
  logic [7:0] i_prefix = 0, i_idx_x = 0, i_idx_y = 0, i_rdata, o_operand;
  logic [15:0] i_pc = 0, o_addr, o_ea, o_next_pc;
  logic [2:0] o_family;
  int n_errors = 0, checks = 0;

  amd_decoder u_amd_decoder (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_start(i_start), .i_mode(i_mode), .i_rmw(i_rmw), .i_inh_op(i_inh_op),
    .i_halt_op(i_halt_op), .i_prefix(i_prefix), .i_idx_x(i_idx_x),
    .i_idx_y(i_idx_y), .i_pc(i_pc), .i_rdata(i_rdata), .i_irq(i_irq),
    .o_addr(o_addr), .o_rd(o_rd), .o_ea(o_ea), .o_operand(o_operand),
    .o_done(o_done), .o_illegal(o_illegal), .o_family(o_family),
    .o_next_pc(o_next_pc), .o_imask(o_imask), .o_halt(o_halt),
    .o_wait(o_wait), .o_busy(o_busy));
  amd_mem_model u_amd_mem_model (.i_clk(i_clk), .i_rd(o_rd),
    .i_addr(o_addr), .o_rdata(i_rdata));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  initial forever #25 i_clk = ~i_clk;

  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task results;
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task go_start(input logic [4:0] m, input logic r, input logic [1:0] op,
                input logic h, input logic [7:0] p);
    @(posedge i_clk); #D;
    i_start = 1; i_mode = m; i_rmw = r;
    i_inh_op = op; i_halt_op = h; i_prefix = p;
    @(posedge i_clk); #D;
    i_start = 0;
  endtask

  // Bounded wait; a missing done shows up as a mismatch on o_done
  task wait_done;
    int n;
    n = 0;
    while (o_done !== 1'b1 && n < 60) begin
      @(posedge i_clk); #D;
      n++;
    end
    chk(o_done, 1);
    ill = o_illegal;
  endtask

  task go(input logic [4:0] m, input logic r, input logic [7:0] p);
    go_start(m, r, `AMD_OP_OTHER, 0, p);
    wait_done;
  endtask

  function automatic logic [2:0] fam_of(input int m);
    if (m < 2) return m[2:0];
    if (m < 4) return `AMD_F_DIR;
    if (m < 7) return `AMD_F_IDX;
    if (m < 11) return `AMD_F_IND;
    if (m < 13) return `AMD_F_REL;
    return `AMD_F_BIT;
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_families;
    for (int m = 0; m < 17; m++) begin
      go(m[4:0], 0, 8'h00);
      chk(o_family, fam_of(m));
      chk(ill, 0);
    end
    go(5'h11, 0, 8'h00);
    chk(ill, 1);
  endtask

  // Lower first: the mask resets high, so raising it first proves nothing
  task t_inherent;
    go_start(`AMD_M_INH, 0, `AMD_OP_UNMASK, 0, 8'h00);
    wait_done;
    chk(o_next_pc, i_pc + 16'h1);
    @(posedge i_clk); #D;
    chk(o_imask, `AMD_MASK_LOW);
    go_start(`AMD_M_INH, 0, `AMD_OP_MASK, 0, 8'h00);
    wait_done;
    @(posedge i_clk); #D;
    chk(o_imask, `AMD_MASK_HIGH);
  endtask

  task t_direct;
    u_amd_mem_model.mem[i_pc + 1] = 8'hc7;
    u_amd_mem_model.mem[i_pc + 2] = 8'hcd;
    go(`AMD_M_IMM, 0, 8'h00);
    chk(o_operand, 8'hc7);
    chk(o_next_pc, i_pc + 16'h2);
    go(`AMD_M_DIR_S, 0, 8'h00);
    chk(o_ea, 16'h00c7);
    go(`AMD_M_DIR_L, 0, 8'h00);
    chk(o_ea, 16'hc7cd);
    chk(o_next_pc, i_pc + 16'h3);
    // Bit-test jump: address byte first, then the jump offset
    go(`AMD_M_BTJ_D, 0, 8'h00);
    chk(o_ea, 16'h00c7);
    chk(o_operand, 8'hcd);
    chk(o_next_pc, i_pc + 16'h3);
  endtask

  task t_indexed;
    i_idx_x = 8'h11;
    i_idx_y = 8'hff;
    u_amd_mem_model.mem[i_pc + 1] = 8'hff;
    u_amd_mem_model.mem[i_pc + 2] = 8'hf0;
    go(`AMD_M_IDX_0, 0, 8'h00);
    chk(o_ea, 16'h0011);
    chk(o_next_pc, i_pc + 16'h1);
    go(`AMD_M_IDX_S, 0, `AMD_Y_PREFIX);
    chk(o_ea, 16'h01fe);
    go(`AMD_M_IDX_L, 0, 8'h00);
    chk(o_ea, 16'h0001);
  endtask

  task t_indirect;
    u_amd_mem_model.mem[i_pc + 1] = 8'h40;
    u_amd_mem_model.mem[16'h0040] = 8'h9a;
    u_amd_mem_model.mem[16'h0041] = 8'h3c;
    go(`AMD_M_IND_S, 0, 8'h00);
    chk(o_ea, 16'h009a);
    chk(o_next_pc, i_pc + 16'h2);
    go(`AMD_M_IND_L, 0, 8'h00);
    chk(o_ea, 16'h9a3c);
    go(`AMD_M_IIX_S, 0, 8'h00);
    chk(o_ea, 16'h00ab);
    go(`AMD_M_IIX_L, 0, 8'h00);
    chk(o_ea, 16'h9a4d);
    // Bit-test jump through a pointer: offset follows pointer address
    u_amd_mem_model.mem[i_pc + 2] = 8'h5e;
    go(`AMD_M_BTJ_I, 0, 8'h00);
    chk(o_ea, 16'h009a);
    chk(o_operand, 8'h5e);
    chk(o_next_pc, i_pc + 16'h3);
  endtask

  task t_rmw;
    go(`AMD_M_DIR_L, 1, 8'h00);
    chk(ill, 1);
    go(`AMD_M_DIR_S, 1, 8'h00);
    chk(ill, 0);
  endtask

  // Sleep states must hold until the interrupt line wakes them
  task t_sleep(input logic h);
    go_start(`AMD_M_INH, 0, h ? `AMD_OP_OTHER : `AMD_OP_WAIT, h, 8'h00);
    repeat (4) @(posedge i_clk);
    #D;
    chk(h ? o_halt : o_wait, 1);
    i_irq = 1;
    wait_done;
    i_irq = 0;
    chk(o_halt | o_wait, 0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge i_clk);
    #D;
    i_nrst = 1;
    repeat (3) @(posedge i_clk);
    #D;
    i_pc = 16'h1230;
    chk(o_imask, `AMD_MASK_RST);
    t_families;
    t_inherent;
    t_direct;
    t_indexed;
    t_indirect;
    t_rmw;
    t_sleep(0);
    t_sleep(1);
    results;
  end

  initial begin
    repeat (5000) @(posedge i_clk);
    n_errors++;
    results;
  end
endmodule
`default_nettype wire
